// file: logic/rx_symbol_decoder.sv
// Combinational 8b/10b decoder for one code group.
// Assumes the caller carries running disparity from symbol to symbol.
`timescale 1ns/10ps
`default_nettype none

module rx_symbol_decoder
(
  input  wire  xaui_rx_pkg::code_type      i_code,
  input  wire  logic                       i_rd_pos,
  output var   xaui_rx_pkg::lane_word_type o_word,
  output var   logic                       o_rd_pos
);
  import xaui_rx_pkg::*;

  // ==========================================================
  // Sub-block split
  // ==========================================================
  wire logic [5:0] six     = {i_code[0], i_code[1], i_code[2], i_code[3], i_code[4], i_code[5]};
  wire logic [3:0] four    = {i_code[6], i_code[7], i_code[8], i_code[9]};
  wire logic       k28     = (six == K28_NEG) || (six == K28_POS);
  // K28_POS inverts its trailing sub-block against the data alphabet
  wire logic [3:0] four_lu = (six == K28_POS) ? ~four : four;
  // Nets must be four-state, so the counts are narrow logic rather than int
  wire logic [2:0] ones6   = 3'($countones(six));
  wire logic [2:0] ones4   = 3'($countones(four));
  wire logic       rd_mid  = (ones6 != SIX_BAL) ? !i_rd_pos : i_rd_pos;

  logic       six_ok;
  logic       four_ok;
  logic [4:0] idx5;
  logic [2:0] idx3;

  // ==========================================================
  // Table search
  // ==========================================================
  always_comb
  begin
    six_ok  = k28;
    four_ok = (four_lu == A7_NEG) || (four_lu == A7_POS);
    idx5    = k28 ? K28_IDX : 5'h00;
    idx3    = four_ok ? 3'(X7_IDX) : 3'h0;
    for (int k = 0; k < 32; k++)
    begin
      if (six == SIX_TABLE[k] || (six == ~SIX_TABLE[k]
          && ($countones(SIX_TABLE[k]) != SIX_BAL || k == D7_IDX)))
      begin
        six_ok = 1'b1;
        idx5   = 5'(k);
      end
    end
    for (int k = 0; k < 8; k++)
    begin
      if (four_lu == FOUR_TABLE[k] || (four_lu == ~FOUR_TABLE[k]
          && ($countones(FOUR_TABLE[k]) != FOUR_BAL || k == X3_IDX)))
      begin
        four_ok = 1'b1;
        idx3    = 3'(k);
      end
    end
  end

  // ==========================================================
  // Disparity check and flags
  // ==========================================================
  wire logic six_derr  = (ones6 > SIX_BAL && i_rd_pos) || (ones6 < SIX_BAL && !i_rd_pos)
                       || (six == SIX_TABLE[D7_IDX] && i_rd_pos)
                       || (six == ~SIX_TABLE[D7_IDX] && !i_rd_pos);
  wire logic four_derr = (ones4 > FOUR_BAL && rd_mid) || (ones4 < FOUR_BAL && !rd_mid)
                       || (four == FOUR_TABLE[X3_IDX] && rd_mid)
                       || (four == ~FOUR_TABLE[X3_IDX] && !rd_mid);
  wire logic bad       = !six_ok || !four_ok || six_derr || four_derr;
  wire logic k_alt     = (four == A7_NEG || four == A7_POS) && KX7_MASK[idx5];

  assign o_word.err  = bad;
  // Flag a K character only when the whole group decoded cleanly
  assign o_word.ctrl = (k28 || k_alt) && !bad;
  assign o_word.data = {idx3, idx5};
  assign o_rd_pos    = (ones4 != FOUR_BAL) ? !rd_mid : rd_mid;

endmodule // rx_symbol_decoder

`default_nettype wire

// file: logic/xaui_rx_parallel_output.sv
// Receive parallel output port: four lanes, decode or raw mode, DDR launch.
// Assumes the deserializer hands over one pair of code groups per lane at a time
// on i_clk; mode straps change only while i_rst is high.
`timescale 1ns/10ps
`default_nettype none

module xaui_rx_parallel_output
(
  input  wire  logic                              i_clk,
  input  wire  logic                              i_rst,
  input  wire  logic                              i_clk_en,
  input  wire  logic                              i_decode_mode,
  input  wire  logic                              i_lane_sync_select,
  input  wire  logic                              i_pair_valid,
  output var   logic                              o_pair_ready,
  input  wire  xaui_rx_pkg::code_pair_type [3:0]  i_code_pair,
  input  wire  logic                              i_lane_a_rec_clk,
  input  wire  logic                              i_lane_b_rec_clk,
  input  wire  logic                              i_lane_c_rec_clk,
  input  wire  logic                              i_lane_d_rec_clk,
  output var   logic                              o_lane_a_rx_clock,
  output var   logic                              o_lane_b_rx_clock,
  output var   logic                              o_lane_c_rx_clock,
  output var   logic                              o_lane_d_rx_clock,
  output var   logic [7:0]                        o_lane_a_rx_bus,
  output var   logic [7:0]                        o_lane_b_rx_bus,
  output var   logic [7:0]                        o_lane_c_rx_bus,
  output var   logic [7:0]                        o_lane_d_rx_bus,
  output var   logic                              o_lane_a_ctrl_flag_bit,
  output var   logic                              o_lane_b_ctrl_flag_bit,
  output var   logic                              o_lane_c_ctrl_flag_bit,
  output var   logic                              o_lane_d_ctrl_flag_bit,
  output var   logic                              o_lane_a_error_flag_bit,
  output var   logic                              o_lane_b_error_flag_bit,
  output var   logic                              o_lane_c_error_flag_bit,
  output var   logic                              o_lane_d_error_flag_bit
);
  import xaui_rx_pkg::*;

  // ==========================================================
  // Word formation
  // ==========================================================
  function automatic lane_word_type make_word(input code_type code,
                                              input lane_word_type dec,
                                              input logic decode);
    lane_word_type raw;
    raw.err  = code[9];
    raw.ctrl = code[8];
    raw.data = code[7:0];
    return decode ? dec : raw;
  endfunction

  // ==========================================================
  // Core domain state
  // ==========================================================
  logic                    mode_meta;
  logic                    mode_reg;
  logic                    lsync_meta;
  logic                    lanesync_reg;
  logic          [3:0]     rd_reg;
  logic          [3:0]     req_reg;
  logic          [3:0]     ack_meta;
  logic          [3:0]     ack_sync;
  word_pair_type [3:0]     hold_reg;
  word_pair_type [3:0]     hold_next;
  lane_word_type [3:0]     dec_first;
  lane_word_type [3:0]     dec_second;
  lane_word_type [3:0]     out_word;
  logic          [3:0]     rd_mid;
  logic          [3:0]     rd_next;
  wire logic     [3:0]     ack_vec;
  wire logic     [3:0]     rec_clk;
  wire logic     [3:0]     lane_clk;
  wire logic     [3:0]     pending;
  wire logic               accept;

  // One pair in flight per lane; the handshake back-pressures the deserializer
  assign pending      = req_reg ^ ack_sync;
  assign o_pair_ready = ~|pending;
  assign accept       = i_pair_valid && o_pair_ready && i_clk_en;

  // Clock select is static: lane sync is a strap, so no glitch-free mux is needed
  assign rec_clk  = {i_lane_d_rec_clk, i_lane_c_rec_clk, i_lane_b_rec_clk, i_lane_a_rec_clk};
  assign lane_clk = lanesync_reg ? {LANES{rec_clk[0]}} : rec_clk;

  for (genvar i = 0; i < LANES; i++)
  begin : g_dec
    rx_symbol_decoder u_dec_first
    (
      .i_code   (i_code_pair[i].first),
      .i_rd_pos (rd_reg[i]),
      .o_word   (dec_first[i]),
      .o_rd_pos (rd_mid[i])
    );
    rx_symbol_decoder u_dec_second
    (
      .i_code   (i_code_pair[i].second),
      .i_rd_pos (rd_mid[i]),
      .o_word   (dec_second[i]),
      .o_rd_pos (rd_next[i])
    );
    assign hold_next[i].first  = make_word(i_code_pair[i].first, dec_first[i], mode_reg);
    assign hold_next[i].second = make_word(i_code_pair[i].second, dec_second[i], mode_reg);
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mode_meta    <= 1'b0;
      mode_reg     <= 1'b0;
      lsync_meta   <= 1'b0;
      lanesync_reg <= 1'b0;
      ack_meta     <= 4'h0;
      ack_sync     <= 4'h0;
      req_reg      <= 4'h0;
      rd_reg       <= {LANES{RD_RESET}};
      hold_reg     <= {2 * LANES{IDLE_WORD}};
    end
    else if (i_clk_en)
    begin
      mode_meta    <= i_decode_mode;
      mode_reg     <= mode_meta;
      lsync_meta   <= i_lane_sync_select;
      lanesync_reg <= lsync_meta;
      ack_meta     <= ack_vec;
      ack_sync     <= ack_meta;
      if (accept)
      begin
        hold_reg <= hold_next;
        rd_reg   <= rd_next;
        req_reg  <= ~req_reg;
      end
    end
  end

  // ==========================================================
  // Link domain: one launcher per lane on the selected clock
  // ==========================================================
  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    logic          req_meta;
    logic          req_sync;
    logic          ack_reg;
    lane_word_type rise_reg;
    lane_word_type fall_pend;
    lane_word_type fall_reg;

    always_ff @(posedge lane_clk[i] or posedge i_rst)
    begin
      if (i_rst)
      begin
        req_meta  <= 1'b0;
        req_sync  <= 1'b0;
        ack_reg   <= 1'b0;
        rise_reg  <= IDLE_WORD;
        fall_pend <= IDLE_WORD;
      end
      else
      begin
        req_meta <= req_reg[i];
        req_sync <= req_meta;
        // Hold registers are stable while the request is outstanding
        if (req_sync != ack_reg)
        begin
          rise_reg  <= hold_reg[i].first;
          fall_pend <= hold_reg[i].second;
          ack_reg   <= req_sync;
        end
      end
    end

    always_ff @(negedge lane_clk[i] or posedge i_rst)
    begin
      if (i_rst)
      begin
        fall_reg <= IDLE_WORD;
      end
      else
      begin
        fall_reg <= fall_pend;
      end
    end

    // DDR launch: high phase shows the first word, low phase the second
    assign out_word[i] = lane_clk[i] ? rise_reg : fall_reg;
    assign ack_vec[i]  = ack_reg;

    a_rise_capture: assert property (@(posedge lane_clk[i]) disable iff (i_rst)
      (req_sync != ack_reg) |=> (rise_reg == $past(hold_reg[i].first)) && (ack_reg == $past(req_sync)))
      else $error("rising word not taken from hold register");
    a_fall_capture: assert property (@(posedge lane_clk[i]) disable iff (i_rst)
      (req_sync != ack_reg) |=> (fall_pend == $past(hold_reg[i].second)))
      else $error("falling word not taken from hold register");
  end

  // ==========================================================
  // Pins
  // ==========================================================
  assign o_lane_a_rx_clock       = lane_clk[0];
  assign o_lane_b_rx_clock       = lane_clk[1];
  assign o_lane_c_rx_clock       = lane_clk[2];
  assign o_lane_d_rx_clock       = lane_clk[3];
  assign o_lane_a_rx_bus         = out_word[0].data;
  assign o_lane_b_rx_bus         = out_word[1].data;
  assign o_lane_c_rx_bus         = out_word[2].data;
  assign o_lane_d_rx_bus         = out_word[3].data;
  assign o_lane_a_ctrl_flag_bit  = out_word[0].ctrl;
  assign o_lane_b_ctrl_flag_bit  = out_word[1].ctrl;
  assign o_lane_c_ctrl_flag_bit  = out_word[2].ctrl;
  assign o_lane_d_ctrl_flag_bit  = out_word[3].ctrl;
  assign o_lane_a_error_flag_bit = out_word[0].err;
  assign o_lane_b_error_flag_bit = out_word[1].err;
  assign o_lane_c_error_flag_bit = out_word[2].err;
  assign o_lane_d_error_flag_bit = out_word[3].err;

  // ==========================================================
  // Checks
  // ==========================================================
  a_ready_pending: assert property (@(posedge i_clk) disable iff (i_rst)
    accept |=> !o_pair_ready)
    else $error("ready stayed high with a pair in flight");
  a_raw_ninth: assert property (@(posedge i_clk) disable iff (i_rst)
    (accept && !mode_reg) |=> hold_reg[0].first.ctrl == $past(i_code_pair[0].first[8]))
    else $error("raw bit 8 is not the ninth code bit");
  a_raw_tenth: assert property (@(posedge i_clk) disable iff (i_rst)
    (accept && !mode_reg) |=> hold_reg[1].second.err == $past(i_code_pair[1].second[9]))
    else $error("raw bit 9 is not the tenth code bit");
  a_ctrl_only_k: assert property (@(posedge i_clk) disable iff (i_rst)
    (accept && mode_reg) |=> hold_reg[2].first.ctrl == $past(dec_first[2].ctrl)
      && !(hold_reg[2].first.ctrl && hold_reg[2].first.err))
    else $error("control flag set without a valid K character");
  a_err_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    (accept && mode_reg && dec_second[3].err) |=> hold_reg[3].second.err)
    else $error("decode error not flagged");
  a_clock_copy: assert property (@(posedge i_clk) disable iff (i_rst)
    lanesync_reg |-> (o_lane_b_rx_clock == o_lane_a_rx_clock)
      && (o_lane_d_rx_clock == i_lane_a_rec_clk))
    else $error("lane clock outputs do not copy lane A clock");
  a_own_clock: assert property (@(posedge i_clk) disable iff (i_rst)
    !lanesync_reg |-> (o_lane_c_rx_clock == i_lane_c_rec_clk))
    else $error("lane C not on its own recovered clock");

endmodule // xaui_rx_parallel_output

`default_nettype wire

// file: logic/xaui_rx_pkg.sv
// Shared types and constants of the receive parallel output port.
// Assumes code groups arrive with bit 0 as the first bit on the line (a).
`default_nettype none

package xaui_rx_pkg;

  // ==========================================================
  // Widths and carriers
  // ==========================================================
  localparam int LANES = 4;

  typedef logic [9:0] code_type;

  typedef struct packed
  {
    logic       err;
    logic       ctrl;
    logic [7:0] data;
  } lane_word_type;

  typedef struct packed
  {
    code_type second;
    code_type first;
  } code_pair_type;

  typedef struct packed
  {
    lane_word_type second;
    lane_word_type first;
  } word_pair_type;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam lane_word_type IDLE_WORD   = 10'h000;
  localparam logic          RD_RESET    = 1'b0;

  // ==========================================================
  // Code tables, sub-blocks written abcdei and fghj, msb first
  // ==========================================================
  localparam logic [5:0] SIX_TABLE [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] FOUR_TABLE [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  localparam logic [5:0]  K28_NEG     = 6'h0F;
  localparam logic [5:0]  K28_POS     = 6'h30;
  localparam logic [4:0]  K28_IDX     = 5'h1C;
  localparam logic [3:0]  A7_NEG      = 4'h7;
  localparam logic [3:0]  A7_POS      = 4'h8;
  localparam logic [31:0] KX7_MASK    = 32'h6880_0000;
  localparam int          D7_IDX      = 7;
  localparam int          X3_IDX      = 3;
  localparam int          X7_IDX      = 7;
  localparam int          SIX_BAL     = 3;
  localparam int          FOUR_BAL    = 2;

endpackage

`default_nettype wire

// file: test/rx_mac_model.sv
// Far-side model: samples each lane's word a little after every forwarded clock edge.
// Assumes half periods of at least 6 ns on the forwarded clocks.
`timescale 1ns/10ps
`default_nettype none

module rx_mac_model
(
  input  wire logic                              i_clear,
  input  wire logic [3:0]                        i_fwd_clk,
  input  wire xaui_rx_pkg::lane_word_type [3:0]  i_word,
  output var  xaui_rx_pkg::lane_word_type [3:0]  o_first,
  output var  xaui_rx_pkg::lane_word_type [3:0]  o_second,
  output var  logic [3:0]                        o_glitch
);
  import xaui_rx_pkg::*;

  // ==========================================================
  // Per-lane capture
  // ==========================================================
  initial o_glitch = 4'h0;
  initial o_first = '0;
  initial o_second = '0;

  genvar l;
  for (l = 0; l < 4; l++)
  begin : g_lane
    lane_word_type held;
    logic          phase;
    always @(i_fwd_clk[l])
    begin
      phase = i_fwd_clk[l];
      #1;
      held = i_word[l];
      #4;
      // A word that moves mid-phase would be missed by a real receiver
      if (i_clear)
        o_glitch[l] = 1'b0;
      else if (i_word[l] !== held)
        o_glitch[l] = 1'b1;
      if (phase)
        o_first[l] = held;
      else
        o_second[l] = held;
    end
  end
endmodule // rx_mac_model

`default_nettype wire

// file: test/testbench.sv
// Self-checking bench of the receive parallel output port.
// Assumes the far-side model in rx_mac_model.sv and the design package.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import xaui_rx_pkg::*;

  // ==========================================================
  // Signals
  // ==========================================================
  logic                 i_clk      = 1'b0;
  logic                 i_rst      = 1'b1;
  logic                 clk_en     = 1'b1;
  logic                 decode     = 1'b0;
  logic                 sync_sel   = 1'b0;
  logic                 pair_valid = 1'b0;
  logic                 clear      = 1'b1;
  logic [3:0]           rec_clk    = 4'h0;
  logic [15:0]          lfsr       = 16'h0017;
  code_pair_type [3:0]  code_pair  = '0;
  wire                  pair_ready;
  wire [3:0]            fwd_clk;
  wire lane_word_type [3:0] word;
  lane_word_type [3:0]  first;
  lane_word_type [3:0]  second;
  logic [3:0]           glitch;
  int                   fail_count = 0;
  int                   checks     = 0;
  int                   cycles     = 0;

  initial forever #2 i_clk = ~i_clk;
  // Lane clocks share a rate, a third of the i_clk rate, but not a phase with each other or with i_clk
  initial begin #0.7; forever #6 rec_clk[0] = ~rec_clk[0]; end
  initial begin #3.3; forever #6 rec_clk[1] = ~rec_clk[1]; end
  initial begin #5.1; forever #6 rec_clk[2] = ~rec_clk[2]; end
  initial begin #2.9; forever #6 rec_clk[3] = ~rec_clk[3]; end

  xaui_rx_parallel_output i_dut
  (
    .i_clk                   (i_clk),
    .i_rst                   (i_rst),
    .i_clk_en                (clk_en),
    .i_decode_mode           (decode),
    .i_lane_sync_select      (sync_sel),
    .i_pair_valid            (pair_valid),
    .o_pair_ready            (pair_ready),
    .i_code_pair             (code_pair),
    .i_lane_a_rec_clk        (rec_clk[0]),
    .i_lane_b_rec_clk        (rec_clk[1]),
    .i_lane_c_rec_clk        (rec_clk[2]),
    .i_lane_d_rec_clk        (rec_clk[3]),
    .o_lane_a_rx_clock       (fwd_clk[0]),
    .o_lane_b_rx_clock       (fwd_clk[1]),
    .o_lane_c_rx_clock       (fwd_clk[2]),
    .o_lane_d_rx_clock       (fwd_clk[3]),
    .o_lane_a_rx_bus         (word[0].data),
    .o_lane_b_rx_bus         (word[1].data),
    .o_lane_c_rx_bus         (word[2].data),
    .o_lane_d_rx_bus         (word[3].data),
    .o_lane_a_ctrl_flag_bit  (word[0].ctrl),
    .o_lane_b_ctrl_flag_bit  (word[1].ctrl),
    .o_lane_c_ctrl_flag_bit  (word[2].ctrl),
    .o_lane_d_ctrl_flag_bit  (word[3].ctrl),
    .o_lane_a_error_flag_bit (word[0].err),
    .o_lane_b_error_flag_bit (word[1].err),
    .o_lane_c_error_flag_bit (word[2].err),
    .o_lane_d_error_flag_bit (word[3].err)
  );

  rx_mac_model i_mac
  (
    .i_clear   (clear),
    .i_fwd_clk (fwd_clk),
    .i_word    (word),
    .o_first   (first),
    .o_second  (second),
    .o_glitch  (glitch)
  );

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Groups are written abcdeifghj with a leftmost; a leaves the port as bit 0
  function automatic code_type flip10(input logic [9:0] v);
    code_type r;
    for (int i = 0; i < 10; i++)
      r[i] = v[9 - i];
    return r;
  endfunction

  // Raw mode: bus is bits 7..0, bit 8 and bit 9 ride on the flag pins
  function automatic logic [9:0] exp_raw(input code_type c);
    return {c[9], c[8], c[7:0]};
  endfunction

  task automatic close_out;
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Straps only move while reset is held
  task automatic do_reset(input logic dec, input logic sync);
    @(negedge i_clk);
    i_rst = 1'b1;
    clear = 1'b1;
    decode = dec;
    sync_sel = sync;
    repeat (6) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (12) @(negedge i_clk);
    clear = 1'b0;
    cmp({9'h000, pair_ready}, 10'h001);
  endtask

  task automatic send(input code_pair_type [3:0] p);
    int n;
    n = 0;
    while (pair_ready !== 1'b1 && n < 400)
    begin
      @(negedge i_clk);
      n++;
    end
    code_pair = p;
    pair_valid = 1'b1;
    @(negedge i_clk);
    pair_valid = 1'b0;
    n = 0;
    // Stall the core side at random while the pair is in flight
    while (pair_ready !== 1'b1 && n < 400)
    begin
      clk_en = lfsr[0] | lfsr[1];
      lfsr = lfsr_next(lfsr);
      @(negedge i_clk);
      n++;
    end
    clk_en = 1'b1;
    repeat (8) @(negedge i_clk);
  endtask

  task automatic check_clk(input logic sync);
    repeat (6)
    begin
      @(negedge i_clk);
      for (int l = 0; l < 4; l++)
        cmp({9'h000, fwd_clk[l]}, {9'h000, sync ? rec_clk[0] : rec_clk[l]});
    end
  endtask

  // ==========================================================
  // Timeout and main sequence
  // ==========================================================
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  initial
  begin
    code_pair_type [3:0] p;
    for (int k = 0; k < 2; k++)
    begin
      do_reset(1'b0, k[0]);
      check_clk(k[0]);
      for (int n = 0; n < 8; n++)
      begin
        for (int l = 0; l < 4; l++)
        begin
          p[l].first = (n == 0) ? 10'h000 : lfsr[9:0];
          lfsr = lfsr_next(lfsr);
          p[l].second = (n == 0) ? 10'h3FF : lfsr[9:0];
          lfsr = lfsr_next(lfsr);
        end
        send(p);
        for (int l = 0; l < 4; l++)
        begin
          cmp(first[l], exp_raw(p[l].first));
          cmp(second[l], exp_raw(p[l].second));
        end
      end
      cmp({6'h00, glitch}, 10'h000);
    end
    do_reset(1'b1, 1'b0);
    // Comma character from negative disparity, then a balanced data group
    for (int l = 0; l < 4; l++)
      p[l] = {flip10(10'b1010101010), flip10(10'b0011111010)};
    send(p);
    for (int l = 0; l < 4; l++)
    begin
      cmp(first[l], 10'h1BC);
      cmp(second[l], 10'h0B5);
    end
    // Same comma again now breaks disparity; all zeros is no code word
    for (int l = 0; l < 4; l++)
      p[l] = {10'h000, flip10(10'b0011111010)};
    send(p);
    for (int l = 0; l < 4; l++)
    begin
      cmp({8'h00, first[l][9:8]}, 10'h002);
      cmp({8'h00, second[l][9:8]}, 10'h002);
    end
    cmp({6'h00, glitch}, 10'h000);
    close_out();
  end
endmodule // testbench

`default_nettype wire
